// File: verilog/rdc_top.sv
`timescale 1ns/10ps
module rdc_top #(
  parameter int MOD_W = 4,
  parameter int FIFO_W = 32,
  parameter int FIFO_D = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modulator words
  input wire logic mod_valid,
  output logic mod_ready,
  input wire logic signed [MOD_W-1:0] mod_l,
  input wire logic signed [MOD_W-1:0] mod_r,
  // Nyquist-rate stereo samples
  output logic pcm_valid,
  input wire logic pcm_ready,
  output logic [FIFO_W-1:0] pcm_data
);

  typedef struct packed {
    logic [4:0] blk;
    logic pwr_l;
    logic pwr_r;
    logic [1:0] osr;
    logic [1:0][2:0] fine;
    logic [1:0][5:0] vol;
    logic [1:0] mute;
    logic [5:0] caddr;
    logic [31:0] rdata;
    logic slverr;
    logic [6:0] cnt;
    logic [1:0][23:0] acc;
    logic [1:0][15:0] dec;
    logic dec_full;
    rdc_pkg::rdc_state_e st;
    logic ch;
    logic [4:0] k;
    logic signed [39:0] acc_f;
    logic [15:0] x;
    logic [1:0][15:0] res;
    logic [1:0][15:0] iir_x;
    logic [1:0][15:0] iir_y;
    logic [1:0][4:0] fwp;
    logic gvld;
  } rdc_top_s;

  rdc_top_s q_r;
  rdc_top_s n;

  logic [15:0] coef_m [64];
  logic [3:0][15:0] bq_m [2][5];
  logic [15:0] fir_m [2][32];

  logic coef_we;
  logic bq_we;
  logic fir_we;
  logic wr;
  logic mapped;
  logic [31:0] rd;
  logic [1:0] ftype;
  logic [2:0] fsel;
  logic [1:0] proc;
  logic right_only;
  logic act_l;
  logic act_r;
  logic osr_ok;
  logic cfg_err;
  logic [4:0] nbq;
  logic [4:0] ntap;
  logic [6:0] osr_last;
  logic [4:0] dsh;
  logic [23:0] sum;
  logic [3:0][15:0] h;
  logic [5:0] cb;
  logic signed [39:0] s_iir;
  logic signed [39:0] s_bq;
  logic signed [39:0] s_fir;
  logic [15:0] y_iir;
  logic [15:0] y_bq;
  logic [1:0] g_vld;
  logic [1:0][15:0] g_smp;
  logic fifo_in_ready;
  logic [$clog2(FIFO_D):0] fifo_lvl;

  function automatic logic signed [39:0] mul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    mul = 40'(p);
  endfunction : mul

  function automatic logic [15:0] sat16(input logic signed [39:0] v);
    logic signed [39:0] s;
    s = v >>> rdc_pkg::COEF_SHIFT;
    if (s > 40'sd32767) begin
      sat16 = 16'h7FFF;
    end else if (s < -40'sd32768) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = 16'(s);
    end
  endfunction : sat16

  function automatic logic is_unit(input int i);
    is_unit = (i == int'(rdc_pkg::C_IIR)) || (i == int'(rdc_pkg::C_FIR)) ||
              ((i >= int'(rdc_pkg::C_BQ)) && (i < int'(rdc_pkg::C_FIR)) &&
               ((i - int'(rdc_pkg::C_BQ)) % 5 == 0));
  endfunction : is_unit

  //////////////////////////////////////////////////////////////////////////////
  // Block decode
  always_comb begin
    ftype = 2'(q_r.blk / rdc_pkg::BLK_PER_TYPE);
    fsel = 3'(q_r.blk % rdc_pkg::BLK_PER_TYPE);
    right_only = fsel >= 3'h3;
    proc = 2'(fsel % 3'h3);
    nbq = (ftype == rdc_pkg::TYPE_B) ? rdc_pkg::BQ_B : rdc_pkg::BQ_AC;
    ntap = (ftype == rdc_pkg::TYPE_B) ? rdc_pkg::TAPS_B : rdc_pkg::TAPS_AC;
    case (ftype)
      rdc_pkg::TYPE_A: osr_ok = (q_r.osr == rdc_pkg::OSR_64) || (q_r.osr == rdc_pkg::OSR_128);
      rdc_pkg::TYPE_B: osr_ok = q_r.osr == rdc_pkg::OSR_64;
      rdc_pkg::TYPE_C: osr_ok = q_r.osr == rdc_pkg::OSR_32;
      default: osr_ok = 1'b0;
    endcase
    cfg_err = (q_r.blk >= rdc_pkg::NUM_BLOCKS) || !osr_ok;
    act_l = q_r.pwr_l && !right_only;
    act_r = q_r.pwr_r;
    case (q_r.osr)
      rdc_pkg::OSR_32: osr_last = 7'h1F;
      rdc_pkg::OSR_64: osr_last = 7'h3F;
      default: osr_last = 7'h7F;
    endcase
    dsh = 5'(16 - MOD_W) - ((q_r.osr == rdc_pkg::OSR_32) ? 5'h05 :
                            (q_r.osr == rdc_pkg::OSR_64) ? 5'h06 : 5'h07);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Filter arithmetic
  always_comb begin
    h = bq_m[q_r.ch][q_r.k[2:0]];
    cb = 6'(rdc_pkg::C_BQ + 6'(q_r.k) * 6'h05);
    s_iir = mul(coef_m[rdc_pkg::C_IIR], q_r.x) +
            mul(coef_m[rdc_pkg::C_IIR + 6'h01], q_r.iir_x[q_r.ch]) +
            mul(coef_m[rdc_pkg::C_IIR + 6'h02], q_r.iir_y[q_r.ch]);
    s_bq = mul(coef_m[cb], q_r.x) + mul(coef_m[cb + 6'h01], h[0]) +
           mul(coef_m[cb + 6'h02], h[1]) + mul(coef_m[cb + 6'h03], h[2]) +
           mul(coef_m[cb + 6'h04], h[3]);
    s_fir = q_r.acc_f + mul(coef_m[rdc_pkg::C_FIR + 6'(q_r.k)],
                            fir_m[q_r.ch][5'(q_r.fwp[q_r.ch] - q_r.k)]);
    y_iir = sat16(s_iir);
    y_bq = sat16(s_bq);
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read mux
  always_comb begin
    rd = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      rdc_pkg::OFF_CTRL: begin
        rd[rdc_pkg::CTRL_BLK_LSB +: 5] = q_r.blk;
        rd[rdc_pkg::CTRL_PWR_L] = q_r.pwr_l;
        rd[rdc_pkg::CTRL_PWR_R] = q_r.pwr_r;
        rd[rdc_pkg::CTRL_OSR_LSB +: 2] = q_r.osr;
      end
      rdc_pkg::OFF_GAIN_L, rdc_pkg::OFF_GAIN_R: begin
        rd[rdc_pkg::GN_FINE_LSB +: 3] = q_r.fine[paddr[3]];
        rd[rdc_pkg::GN_VOL_LSB +: 6] = q_r.vol[paddr[3]];
        rd[rdc_pkg::GN_MUTE] = q_r.mute[paddr[3]];
      end
      rdc_pkg::OFF_CADDR: rd[5:0] = q_r.caddr;
      rdc_pkg::OFF_CDATA: rd[15:0] = coef_m[q_r.caddr];
      rdc_pkg::OFF_STAT: begin
        rd[rdc_pkg::ST_ERR] = cfg_err;
        rd[rdc_pkg::ST_BUSY] = q_r.st != rdc_pkg::ST_IDLE;
        rd[rdc_pkg::ST_DECF] = q_r.dec_full;
        rd[rdc_pkg::ST_LVL_LSB +: 6] = 6'(fifo_lvl);
      end
      default: mapped = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = q_r;
    n.gvld = 1'b0;
    coef_we = 1'b0;
    bq_we = 1'b0;
    fir_we = 1'b0;
    sum = 24'h00_0000;
    wr = psel && penable && pwrite;
    // Read data and error are prepared in the setup cycle, so pready never waits
    if (psel && !penable) begin
      n.rdata = pwrite ? 32'h0000_0000 : rd;
      n.slverr = !mapped;
    end
    if (wr) begin
      case (paddr)
        rdc_pkg::OFF_CTRL: begin
          n.blk = pwdata[rdc_pkg::CTRL_BLK_LSB +: 5];
          n.pwr_l = pwdata[rdc_pkg::CTRL_PWR_L];
          n.pwr_r = pwdata[rdc_pkg::CTRL_PWR_R];
          n.osr = pwdata[rdc_pkg::CTRL_OSR_LSB +: 2];
        end
        rdc_pkg::OFF_GAIN_L, rdc_pkg::OFF_GAIN_R: begin
          n.fine[paddr[3]] = pwdata[rdc_pkg::GN_FINE_LSB +: 3];
          n.vol[paddr[3]] = pwdata[rdc_pkg::GN_VOL_LSB +: 6];
          n.mute[paddr[3]] = pwdata[rdc_pkg::GN_MUTE];
        end
        rdc_pkg::OFF_CADDR: n.caddr = pwdata[5:0];
        rdc_pkg::OFF_CDATA: begin
          coef_we = 1'b1;
          n.caddr = q_r.caddr + 6'h01;
        end
        default: ;
      endcase
    end

    // integrate and dump over the oversampling ratio
    if (mod_valid && !q_r.dec_full) begin
      for (int c = 0; c < 2; c++) begin
        sum = q_r.acc[c] + 24'((c == 0) ? mod_l : mod_r);
        if (q_r.cnt == osr_last) begin
          n.dec[c] = 16'(sum <<< dsh);
          n.acc[c] = 24'h00_0000;
        end else begin
          n.acc[c] = sum;
        end
      end
      n.cnt = (q_r.cnt == osr_last) ? 7'h00 : q_r.cnt + 7'h01;
      n.dec_full = q_r.cnt == osr_last;
    end

    case (q_r.st)
      rdc_pkg::ST_IDLE: begin
        // Starts only with FIFO room and nothing in the gain stage
        if (q_r.dec_full && fifo_in_ready && !q_r.gvld && !g_vld[0] && !cfg_err &&
            (act_l || act_r)) begin
          n.res[0] = act_l ? q_r.dec[0] : 16'h0000;
          n.res[1] = act_r ? q_r.dec[1] : 16'h0000;
          n.ch = !act_l;
          n.x = act_l ? q_r.dec[0] : q_r.dec[1];
          n.dec_full = 1'b0;
          n.st = rdc_pkg::ST_IIR;
        end else if (q_r.dec_full && (cfg_err || !(act_l || act_r))) begin
          n.dec_full = 1'b0;
        end
      end
      rdc_pkg::ST_IIR: begin
        // every block runs the IIR first
        n.iir_x[q_r.ch] = q_r.x;
        n.iir_y[q_r.ch] = y_iir;
        n.x = y_iir;
        n.k = 5'h00;
        n.acc_f = 40'sd0;
        case (proc)
          2'h1: n.st = rdc_pkg::ST_BQ;
          2'h2: begin
            fir_we = 1'b1;
            n.st = rdc_pkg::ST_FIR;
          end
          default: n.st = rdc_pkg::ST_NEXT;
        endcase
      end
      rdc_pkg::ST_BQ: begin
        bq_we = 1'b1;
        n.x = y_bq;
        n.k = q_r.k + 5'h01;
        if (q_r.k == nbq - 5'h01) begin
          n.st = rdc_pkg::ST_NEXT;
        end
      end
      rdc_pkg::ST_FIR: begin
        n.acc_f = s_fir;
        n.k = q_r.k + 5'h01;
        if (q_r.k == ntap - 5'h01) begin
          n.x = sat16(s_fir);
          n.fwp[q_r.ch] = q_r.fwp[q_r.ch] + 5'h01;
          n.st = rdc_pkg::ST_NEXT;
        end
      end
      rdc_pkg::ST_NEXT: begin
        n.res[q_r.ch] = q_r.x;
        if (!q_r.ch && act_r) begin
          n.ch = 1'b1;
          n.x = q_r.res[1];
          n.st = rdc_pkg::ST_IIR;
        end else begin
          n.st = rdc_pkg::ST_PUSH;
        end
      end
      rdc_pkg::ST_PUSH: begin
        n.gvld = 1'b1;
        n.st = rdc_pkg::ST_IDLE;
      end
      default: n.st = rdc_pkg::ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
      q_r.blk <= rdc_pkg::DEFAULT_RECORD_BLOCK;
      q_r.osr <= rdc_pkg::OSR_RST;
      q_r.st <= rdc_pkg::ST_IDLE;
    end else begin
      q_r <= n;
    end
  end

  // Coefficients reset to a pass-through response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) begin
        coef_m[i] <= is_unit(i) ? rdc_pkg::COEF_ONE : 16'h0000;
      end
      for (int c = 0; c < 2; c++) begin
        for (int j = 0; j < 5; j++) begin
          bq_m[c][j] <= '0;
        end
        for (int j = 0; j < 32; j++) begin
          fir_m[c][j] <= 16'h0000;
        end
      end
    end else begin
      if (coef_we) begin
        coef_m[q_r.caddr] <= pwdata[15:0];
      end
      if (bq_we) begin
        bq_m[q_r.ch][q_r.k[2:0]] <= {h[2], y_bq, h[0], q_r.x};
      end
      if (fir_we) begin
        fir_m[q_r.ch][q_r.fwp[q_r.ch]] <= y_iir;
      end
    end
  end

  assign prdata = q_r.rdata;
  assign pready = 1'b1;
  assign pslverr = q_r.slverr;
  assign mod_ready = !q_r.dec_full;

  //////////////////////////////////////////////////////////////////////////////
  // Gain stages and output buffer
  for (genvar c = 0; c < 2; c++) begin : g_ch
    rdc_gain u_gain (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(q_r.gvld),
      .smp_in(q_r.res[c]),
      .fine(q_r.fine[c]),
      .vol(q_r.vol[c]),
      .mute(q_r.mute[c]),
      .out_valid(g_vld[c]),
      .smp_out(g_smp[c])
    );
  end

  rdc_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(&g_vld),
    .in_ready(fifo_in_ready),
    .in_data(FIFO_W'({g_smp[0], g_smp[1]})),
    .out_valid(pcm_valid),
    .out_ready(pcm_ready),
    .out_data(pcm_data),
    .level(fifo_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_DEFAULT_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> q_r.blk == rdc_pkg::DEFAULT_RECORD_BLOCK && q_r.osr == rdc_pkg::OSR_128)
    else $error("reset block not default");

  AST_BAD_RATIO_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    q_r.st == rdc_pkg::ST_IDLE && cfg_err |=> q_r.st == rdc_pkg::ST_IDLE)
    else $error("engine started with bad ratio");

  AST_DECIM_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q_r.dec_full) |-> $past(q_r.cnt) == $past(osr_last) && $past(mod_valid))
    else $error("decimated sample at wrong count");

  AST_RIGHT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    q_r.st == rdc_pkg::ST_IDLE && right_only ##1 q_r.st == rdc_pkg::ST_IIR |-> q_r.ch)
    else $error("left channel ran in right-only block");

  AST_BQ_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    q_r.st == rdc_pkg::ST_BQ && q_r.k == nbq - 5'h01 |=> q_r.st == rdc_pkg::ST_NEXT)
    else $error("biquad chain length wrong");

  AST_FIR_TAPS: assert property (@(posedge pclk) disable iff (!presetn)
    q_r.st == rdc_pkg::ST_FIR |-> q_r.k < ntap)
    else $error("FIR ran past its taps");

  AST_COEF_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == rdc_pkg::OFF_CDATA |=> coef_m[$past(q_r.caddr)] == $past(pwdata[15:0]))
    else $error("coefficient not stored");

  AST_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    q_r.st == rdc_pkg::ST_IDLE ##1 q_r.st == rdc_pkg::ST_IIR |-> ##[1:60] q_r.gvld)
    else $error("sample took too long for top rate");

endmodule : rdc_top

// File: shared/rdc_pkg.sv
package rdc_pkg;

  // Rate figures
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned FS_MIN_HZ = 8000;
  localparam int unsigned FS_MAX_HZ = 192000;
  localparam int unsigned FS_MAX_CYC = CLK_HZ / FS_MAX_HZ;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GAIN_L = 8'h04;
  localparam logic [7:0] OFF_GAIN_R = 8'h08;
  localparam logic [7:0] OFF_CADDR = 8'h0C;
  localparam logic [7:0] OFF_CDATA = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;

  // Field positions
  localparam int CTRL_BLK_LSB = 0;
  localparam int CTRL_PWR_L = 8;
  localparam int CTRL_PWR_R = 9;
  localparam int CTRL_OSR_LSB = 10;
  localparam int GN_FINE_LSB = 0;
  localparam int GN_VOL_LSB = 8;
  localparam int GN_MUTE = 16;
  localparam int ST_ERR = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_DECF = 2;
  localparam int ST_LVL_LSB = 8;

  // Reset values
  localparam logic [4:0] DEFAULT_RECORD_BLOCK = 5'h00;
  localparam logic [1:0] OSR_32 = 2'h0;
  localparam logic [1:0] OSR_64 = 2'h1;
  localparam logic [1:0] OSR_128 = 2'h2;
  localparam logic [1:0] OSR_RST = OSR_128;
  localparam logic [15:0] COEF_ONE = 16'h4000;

  // Block map and counts
  localparam logic [4:0] NUM_BLOCKS = 5'h12;
  localparam logic [4:0] BLK_PER_TYPE = 5'h06;
  localparam logic [1:0] TYPE_A = 2'h0;
  localparam logic [1:0] TYPE_B = 2'h1;
  localparam logic [1:0] TYPE_C = 2'h2;
  localparam logic [4:0] BQ_AC = 5'h05;
  localparam logic [4:0] BQ_B = 5'h03;
  localparam logic [4:0] TAPS_AC = 5'h19;
  localparam logic [4:0] TAPS_B = 5'h14;
  localparam int COEF_SHIFT = 14;
  localparam logic [5:0] C_IIR = 6'h00;
  localparam logic [5:0] C_BQ = 6'h03;
  localparam logic [5:0] C_FIR = 6'h1C;
  localparam logic [3:0] FINE_MAX = 4'h4;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_IIR = 6'h02,
    ST_BQ = 6'h04,
    ST_FIR = 6'h08,
    ST_NEXT = 6'h10,
    ST_PUSH = 6'h20
  } rdc_state_e;

endpackage : rdc_pkg

// File: verilog/rdc_fifo.sv
`timescale 1ns/10ps
// Depth must be a power of two
module rdc_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } rdc_fifo_s;

  rdc_fifo_s q_r;
  rdc_fifo_s q_nxt;
  logic [W-1:0] mem [D];

  assign level = q_r.wp - q_r.rp;
  assign in_ready = level != (AW + 1)'(D);
  assign out_valid = level != '0;
  assign out_data = mem[q_r.rp[AW-1:0]];

  always_comb begin
    q_nxt = q_r;
    if (in_valid && in_ready) begin
      q_nxt.wp = q_r.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      q_nxt.rp = q_r.rp + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Storage needs no reset; out_valid guards every read
  always_ff @(posedge pclk) begin
    if (in_valid && in_ready) begin
      mem[q_r.wp[AW-1:0]] <= in_data;
    end
  end

endmodule : rdc_fifo

// File: verilog/rdc_gain.sv
`timescale 1ns/10ps
module rdc_gain (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample in
  input wire logic in_valid,
  input wire logic signed [15:0] smp_in,
  // Settings
  input wire logic [2:0] fine,
  input wire logic signed [5:0] vol,
  input wire logic mute,
  // Sample out
  output logic out_valid,
  output logic [15:0] smp_out
);
  // Fine steps 0 to -0.4 dB, volume steps of 1 dB within one 6 dB octave
  localparam logic [15:0] FINE_TAB [5] = '{16'h4000, 16'h3F44, 16'h3E8B, 16'h3DD4, 16'h3D1F};
  localparam logic [15:0] STEP_TAB [6] = '{16'h4000, 16'h47CF, 16'h5092, 16'h5A67, 16'h656F,
                                           16'h71CF};

  typedef struct packed {
    logic vld;
    logic [15:0] smp;
  } rdc_gain_s;

  rdc_gain_s q_r;
  rdc_gain_s q_nxt;
  logic [2:0] fi;
  logic [5:0] v;
  logic [2:0] oct;
  logic [2:0] r;
  logic signed [32:0] p1;
  logic signed [17:0] g1;
  logic signed [35:0] p2;
  logic signed [40:0] p3;

  always_comb begin
    q_nxt = q_r;
    fi = (fine > 3'h4) ? 3'h4 : fine;
    if (vol < -6'sd12) begin
      v = 6'h00;
    end else if (vol > 6'sd20) begin
      v = 6'h20;
    end else begin
      v = 6'(vol + 6'sd12);
    end
    oct = 3'(v / 6'h06);
    r = 3'(v % 6'h06);
    p1 = smp_in * $signed({1'b0, FINE_TAB[fi]});
    g1 = 18'(p1 >>> 14);
    p2 = g1 * $signed({1'b0, STEP_TAB[r]});
    p3 = (41'(p2) <<< oct) >>> 16;
    q_nxt.vld = in_valid;
    if (in_valid) begin
      if (p3 > 41'sd32767) begin
        q_nxt.smp = 16'h7FFF;
      end else if (p3 < -41'sd32768) begin
        q_nxt.smp = 16'h8000;
      end else begin
        q_nxt.smp = 16'(p3);
      end
      if (mute) begin
        q_nxt.smp = 16'h0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign out_valid = q_r.vld;
  assign smp_out = q_r.smp;

  AST_MUTE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid && mute |=> out_valid && smp_out == 16'h0000)
    else $error("muted sample not zero");

  AST_UNITY_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid && !mute && fine == 3'h0 && vol == 6'sd0 |=> smp_out == $past(smp_in))
    else $error("0 dB setting changed the sample");

endmodule : rdc_gain

// File: tb/rdc_partner.sv
`timescale 1ns/10ps
module rdc_partner #(
  parameter int MOD_W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic run,
  input wire logic sink_on,
  input wire logic [MOD_W-1:0] word,
  // Modulator side
  output logic mod_valid,
  input wire logic mod_ready,
  output logic signed [MOD_W-1:0] mod_l,
  output logic signed [MOD_W-1:0] mod_r,
  // Sample sink
  output logic pcm_ready
);
  //////////////////////////////////////////////////////////////////////////////
  // oversampled word stream
  // Idle lines toggle so a stale word is never mistaken for a fresh one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_valid <= 1'b0;
      mod_l <= '0;
      mod_r <= '1;
      pcm_ready <= 1'b0;
    end else begin
      if (!mod_valid || mod_ready) begin
        if (run && ($urandom_range(0, 3) != 0)) begin
          mod_valid <= 1'b1;
          mod_l <= ~word;
          mod_r <= word;
        end else begin
          mod_valid <= 1'b0;
          mod_l <= ~mod_l;
          mod_r <= ~mod_r;
        end
      end
      pcm_ready <= sink_on && ($urandom_range(0, 1) != 0);
    end
  end
endmodule : rdc_partner

// File: tb/adc_record_decimation_chain_tb_top.sv
`timescale 1ns/10ps
module adc_record_decimation_chain_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pcm_data, last, rd;
  logic mod_valid, mod_ready, pcm_valid, pcm_ready, run, sink_on, er;
  logic signed [3:0] mod_l, mod_r;
  logic [3:0] w, nw;
  int n_mismatch, tests_run, pops, n0, k;

  rdc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_valid(mod_valid), .mod_ready(mod_ready), .mod_l(mod_l),
    .mod_r(mod_r), .pcm_valid(pcm_valid), .pcm_ready(pcm_ready), .pcm_data(pcm_data));
  rdc_partner prt (.pclk(pclk), .presetn(presetn), .run(run), .sink_on(sink_on),
    .word(w), .mod_valid(mod_valid), .mod_ready(mod_ready), .mod_l(mod_l),
    .mod_r(mod_r), .pcm_ready(pcm_ready));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (pcm_valid && pcm_ready) begin
      last <= pcm_data;
      pops <= pops + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("Counts tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic fail();
    n_mismatch++;
    results();
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (j == 50) fail();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected sample: decimator gain cancels the ratio, so v lands at bit 12
  // Mode 1 halves it (6 dB down), mode 2 applies one 0.1 dB fine step
  function automatic logic [15:0] smp(input logic [3:0] v, input int hl);
    if (hl == 2) begin
      return 16'($rtoi($signed(v) * 4096.0 * (10.0 ** (-0.005))));
    end
    return (hl == 1) ? {v[3], v, 11'h000} : {v, 12'h000};
  endfunction : smp

  // First words after a change may mix old settings, so the fourth is judged
  task automatic scen(input string nm, input logic [31:0] ctrl, input logic [31:0] gl,
      input logic kl, input int hl);
    nw = 4'($urandom_range(0, 15));
    w <= nw;
    apb(1'b1, rdc_pkg::OFF_CTRL, ctrl);
    apb(1'b1, rdc_pkg::OFF_GAIN_L, gl);
    n0 = pops;
    for (k = 0; k < 5000; k++) begin
      @(posedge pclk);
      if (pops >= n0 + 4) break;
    end
    if (k == 5000) fail();
    chk(last, {kl ? smp(~nw, hl) : 16'h0000, smp(nw, hl)});
    $display("test %s done", nm);
  endtask : scen

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, run, sink_on} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    w = 4'h0;
    pops = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(2));
    apb(1'b0, rdc_pkg::OFF_CTRL, 32'h00000000);
    chk(rd, 32'(rdc_pkg::OSR_RST) << rdc_pkg::CTRL_OSR_LSB);
    apb(1'b0, rdc_pkg::OFF_CDATA, 32'h00000000);
    chk(rd, 32'(rdc_pkg::COEF_ONE));
    apb(1'b0, 8'hFC, 32'h00000000);
    chk(32'(er), 32'h00000001);
    $display("test reset done");
    run <= 1'b1;
    sink_on <= 1'b1;
    scen("stereo", 32'h00000B00, 32'h0, 1'b1, 1'b0);
    scen("ratio64", 32'h00000700, 32'h0, 1'b1, 1'b0);
    scen("type_b", 32'h00000706, 32'h0, 1'b1, 1'b0);
    scen("fir_b", 32'h00000708, 32'h0, 1'b1, 1'b0);
    scen("type_c", 32'h0000030C, 32'h0, 1'b1, 1'b0);
    scen("biquad_c", 32'h0000030D, 32'h0, 1'b1, 1'b0);
    apb(1'b0, rdc_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[rdc_pkg::ST_ERR]), 32'h0);
    scen("mono", 32'h00000A00, 32'h0, 1'b0, 1'b0);
    scen("right_blk", 32'h00000B03, 32'h0, 1'b0, 1'b0);
    scen("mute", 32'h00000B00, 32'h00010000, 1'b0, 1'b0);
    scen("unmute", 32'h00000B00, 32'h0, 1'b1, 1'b0);
    apb(1'b1, rdc_pkg::OFF_GAIN_R, 32'h00000001);
    scen("fine", 32'h00000B00, 32'h00000001, 1'b1, 2);
    apb(1'b1, rdc_pkg::OFF_GAIN_R, 32'h00003A00);
    scen("volume", 32'h00000B00, 32'h00003A00, 1'b1, 1);
    apb(1'b1, rdc_pkg::OFF_GAIN_R, 32'h0);
    apb(1'b1, rdc_pkg::OFF_CADDR, 32'h0);
    apb(1'b1, rdc_pkg::OFF_CDATA, 32'h00002000);
    apb(1'b1, rdc_pkg::OFF_CADDR, 32'h0);
    apb(1'b0, rdc_pkg::OFF_CDATA, 32'h0);
    chk(rd, 32'h00002000);
    scen("coef", 32'h00000B00, 32'h0, 1'b1, 1'b1);
    apb(1'b1, rdc_pkg::OFF_CTRL, 32'h00000B06);
    apb(1'b0, rdc_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[rdc_pkg::ST_ERR]), 32'h1);
    $display("test mismatch done");
    apb(1'b1, rdc_pkg::OFF_CTRL, 32'h00000B00);
    sink_on <= 1'b0;
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, rdc_pkg::OFF_STAT, 32'h0);
      if (rd[13:8] == 6'h20 && rd[rdc_pkg::ST_DECF]) break;
    end
    if (k == 3000) fail();
    chk(32'(pcm_valid), 32'h1);
    chk(32'(mod_ready), 32'h0);
    n0 = pops;
    run <= 1'b0;
    sink_on <= 1'b1;
    for (k = 0; k < 3000; k++) begin
      @(posedge pclk);
      if (pcm_valid === 1'b0 && pops - n0 >= 32) break;
    end
    if (k == 3000) fail();
    apb(1'b0, rdc_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[13:8]), 32'h0);
    $display("test fifo done");
    results();
  end
endmodule : adc_record_decimation_chain_tb_top
